// [shared/awd_pkg.sv]
// Purpose: Shared constants for the converter window detector block
// Assumes: 8-bit special-function-register bus, 16-bit limit and result words
// Notes: Every address, reset value, field position and mode code lives here

package awd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Special-function-register addresses
  localparam logic [7:0] AWD_ADDR_UPPER_LOW = 8'hc3;
  localparam logic [7:0] AWD_ADDR_UPPER_HIGH = 8'hc4;
  localparam logic [7:0] AWD_ADDR_LOWER_LOW = 8'hc5;
  localparam logic [7:0] AWD_ADDR_LOWER_HIGH = 8'hc6;
  localparam logic [7:0] AWD_ADDR_CONTROL = 8'he8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] AWD_RST_UPPER = 8'hff;
  localparam logic [7:0] AWD_RST_LOWER = 8'h00;
  localparam logic [7:0] AWD_RST_CONTROL = 8'h00;
  localparam logic [7:0] AWD_UNMAPPED_READ = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Control register field positions
  localparam int AWD_BIT_ENABLE = 7;
  localparam int AWD_BIT_TRACK = 6;
  localparam int AWD_BIT_DONE = 5;
  localparam int AWD_BIT_BUSY = 4;
  localparam int AWD_BIT_WINDOW = 3;
  localparam int AWD_MODE_MSB = 2;
  localparam int AWD_MODE_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Start-of-conversion source codes
  typedef enum logic [2:0] {
    AWD_START_SOFTWARE = 3'h0,
    AWD_START_AUX0 = 3'h1,
    AWD_START_AUX1 = 3'h2,
    AWD_START_AUX2 = 3'h3,
    AWD_START_EXTERNAL = 3'h4,
    AWD_START_TIMER3 = 3'h5,
    AWD_START_RSVD0 = 3'h6,
    AWD_START_RSVD1 = 3'h7
  } awd_start_type;

  localparam int AWD_AUX_SOURCES = 3;

endpackage : awd_pkg

// [rtl/awd_start_sel.sv]
// Purpose: Picks the start-of-conversion source and issues one start pulse
// Assumes: External start pin is asynchronous; timer and aux strobes are on i_clk_sys
// Notes: Start pulse comes from a flip-flop, two to three cycles after a pin edge

`timescale 1ns/1ps
`default_nettype none

module awd_start_sel
  import awd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Source selection and triggers
  input wire logic [2:0] i_mode,
  input wire logic i_sw_start,
  input wire logic i_ext_pin,
  input wire logic i_timer3_ovf,
  input wire logic [AWD_AUX_SOURCES-1:0] i_aux_ovf,
  // Start strobe
  output logic o_start
);

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic ext_rise;
  logic start_next;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser; the third flop only serves the edge detector
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= i_ext_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign ext_rise = sync2_reg & ~sync3_reg;

  // Source mux; reserved codes never start anything
  always_comb begin
    start_next = 1'b0;
    case (awd_start_type'(i_mode))
      AWD_START_SOFTWARE: start_next = i_sw_start;
      AWD_START_AUX0: start_next = i_aux_ovf[0];
      AWD_START_AUX1: start_next = i_aux_ovf[1];
      AWD_START_AUX2: start_next = i_aux_ovf[2];
      AWD_START_EXTERNAL: start_next = ext_rise;
      AWD_START_TIMER3: start_next = i_timer3_ovf;
      default: start_next = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_start <= 1'b0;
    end else begin
      o_start <= start_next;
    end
  end

  a_timer3_start: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_mode == AWD_START_TIMER3 && i_timer3_ovf) |=> o_start)
    else $error("timer 3 overflow did not start a conversion");

  a_pin_edge_start: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_mode == AWD_START_EXTERNAL && $stable(i_mode) && sync2_reg && !sync3_reg)
    |=> o_start)
    else $error("external pin rising edge did not start a conversion");

endmodule : awd_start_sel

`default_nettype wire

// [rtl/awd_top.sv]
// Purpose: Window comparator and start-source control of a 10-bit converter
// Assumes: Result word and its done strobe come from the conversion core
// Notes: Registers sit on the special-function-register bus at fixed addresses

`timescale 1ns/1ps
`default_nettype none

module awd_top
  import awd_pkg::*;
#(
  parameter int DATA_WIDTH = 16
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Special-function-register bus
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Conversion core
  input wire logic [DATA_WIDTH-1:0] i_result_data,
  input wire logic i_result_valid,
  output logic o_convert_start,
  output logic o_adc_enable,
  output logic o_track_delayed,
  // Start triggers
  input wire logic i_ext_convert_start_pin,
  input wire logic i_timer3_ovf,
  input wire logic [AWD_AUX_SOURCES-1:0] i_aux_ovf,
  // Status
  output logic o_window_match_flag,
  output logic o_conversion_done_flag,
  output logic o_busy
);

  logic [7:0] upper_high_reg;
  logic [7:0] upper_low_reg;
  logic [7:0] lower_high_reg;
  logic [7:0] lower_low_reg;
  logic enable_reg;
  logic track_reg;
  logic done_reg;
  logic busy_reg;
  logic window_reg;
  logic [2:0] mode_reg;
  logic [7:0] rdata_next;
  logic [7:0] control_value;
  logic [15:0] upper_word;
  logic [15:0] lower_word;
  logic [15:0] result_word;
  logic window_hit;
  logic start_pulse;
  logic sw_start;
  logic wr_upper_high;
  logic wr_upper_low;
  logic wr_lower_high;
  logic wr_lower_low;
  logic wr_control;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    wr_upper_high = 1'b0;
    wr_upper_low = 1'b0;
    wr_lower_high = 1'b0;
    wr_lower_low = 1'b0;
    wr_control = 1'b0;
    if (i_sfr_addr == AWD_ADDR_UPPER_HIGH) begin
      wr_upper_high = i_sfr_wr;
    end else if (i_sfr_addr == AWD_ADDR_UPPER_LOW) begin
      wr_upper_low = i_sfr_wr;
    end else if (i_sfr_addr == AWD_ADDR_LOWER_HIGH) begin
      wr_lower_high = i_sfr_wr;
    end else if (i_sfr_addr == AWD_ADDR_LOWER_LOW) begin
      wr_lower_low = i_sfr_wr;
    end else if (i_sfr_addr == AWD_ADDR_CONTROL) begin
      wr_control = i_sfr_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      upper_high_reg <= AWD_RST_UPPER;
      upper_low_reg <= AWD_RST_UPPER;
      lower_high_reg <= AWD_RST_LOWER;
      lower_low_reg <= AWD_RST_LOWER;
    end else begin
      if (wr_upper_high) begin
        upper_high_reg <= i_sfr_wdata;
      end
      if (wr_upper_low) begin
        upper_low_reg <= i_sfr_wdata;
      end
      if (wr_lower_high) begin
        lower_high_reg <= i_sfr_wdata;
      end
      if (wr_lower_low) begin
        lower_low_reg <= i_sfr_wdata;
      end
    end
  end

  // High byte above low byte forms each 16-bit limit word
  assign upper_word = {upper_high_reg, upper_low_reg};
  assign lower_word = {lower_high_reg, lower_low_reg};
  assign result_word = 16'(i_result_data);

  ////////////////////////////////////////////////////////////////////////////
  // Window compare; no polarity bit, the limit ordering picks inside/outside
  always_comb begin
    if (lower_word > upper_word) begin
      window_hit = (result_word > upper_word) && (result_word < lower_word);
    end else begin
      window_hit = (result_word < lower_word) || (result_word > upper_word);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register: mode and option bits
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable_reg <= AWD_RST_CONTROL[AWD_BIT_ENABLE];
      track_reg <= AWD_RST_CONTROL[AWD_BIT_TRACK];
      mode_reg <= AWD_RST_CONTROL[AWD_MODE_MSB:AWD_MODE_LSB];
    end else if (wr_control) begin
      enable_reg <= i_sfr_wdata[AWD_BIT_ENABLE];
      track_reg <= i_sfr_wdata[AWD_BIT_TRACK];
      mode_reg <= i_sfr_wdata[AWD_MODE_MSB:AWD_MODE_LSB];
    end
  end

  // Writing one to busy in software mode is the start request
  assign sw_start = wr_control && i_sfr_wdata[AWD_BIT_BUSY]
                    && (mode_reg == AWD_START_SOFTWARE);

  // Sticky window flag: a hit in the clearing cycle wins so no event is lost
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      window_reg <= AWD_RST_CONTROL[AWD_BIT_WINDOW];
    end else if (i_result_valid && window_hit) begin
      window_reg <= 1'b1;
    end else if (wr_control) begin
      window_reg <= i_sfr_wdata[AWD_BIT_WINDOW];
    end
  end

  // Conversion-complete flag, same set-over-clear priority
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_reg <= AWD_RST_CONTROL[AWD_BIT_DONE];
    end else if (i_result_valid) begin
      done_reg <= 1'b1;
    end else if (wr_control) begin
      done_reg <= i_sfr_wdata[AWD_BIT_DONE];
    end
  end

  // Busy rises with the start strobe and falls when the result arrives
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_reg <= AWD_RST_CONTROL[AWD_BIT_BUSY];
    end else if (start_pulse) begin
      busy_reg <= 1'b1;
    end else if (i_result_valid) begin
      busy_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start source selection
  awd_start_sel u_start_sel (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_mode(mode_reg),
    .i_sw_start(sw_start),
    .i_ext_pin(i_ext_convert_start_pin),
    .i_timer3_ovf(i_timer3_ovf),
    .i_aux_ovf(i_aux_ovf),
    .o_start(start_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path, registered so the bus sees data one cycle after the address
  always_comb begin
    control_value = {enable_reg, track_reg, done_reg, busy_reg, window_reg, mode_reg};
    if (i_sfr_addr == AWD_ADDR_UPPER_HIGH) begin
      rdata_next = upper_high_reg;
    end else if (i_sfr_addr == AWD_ADDR_UPPER_LOW) begin
      rdata_next = upper_low_reg;
    end else if (i_sfr_addr == AWD_ADDR_LOWER_HIGH) begin
      rdata_next = lower_high_reg;
    end else if (i_sfr_addr == AWD_ADDR_LOWER_LOW) begin
      rdata_next = lower_low_reg;
    end else if (i_sfr_addr == AWD_ADDR_CONTROL) begin
      rdata_next = control_value;
    end else begin
      rdata_next = AWD_UNMAPPED_READ;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sfr_rdata <= AWD_UNMAPPED_READ;
    end else begin
      o_sfr_rdata <= rdata_next;
    end
  end

  // Remaining outputs, each from its own flop
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_convert_start <= 1'b0;
      o_adc_enable <= 1'b0;
      o_track_delayed <= 1'b0;
      o_window_match_flag <= 1'b0;
      o_conversion_done_flag <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_convert_start <= start_pulse;
      o_adc_enable <= enable_reg;
      o_track_delayed <= track_reg;
      o_window_match_flag <= window_reg;
      o_conversion_done_flag <= done_reg;
      o_busy <= busy_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_inside_window: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_result_valid && lower_word > upper_word && result_word > upper_word
     && result_word < lower_word) |=> ##1 o_window_match_flag)
    else $error("inside-window result did not raise the flag");

  a_outside_window: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_result_valid && lower_word <= upper_word && result_word < lower_word)
    |=> window_reg)
    else $error("result below lower limit did not raise the flag");

  a_no_false_hit: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (!window_reg && !(i_result_valid && window_hit) && !(wr_control
     && i_sfr_wdata[AWD_BIT_WINDOW])) |=> !window_reg)
    else $error("window flag set without a match");

  a_flag_sticky: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (window_reg && !wr_control) |=> window_reg)
    else $error("window flag dropped without a software write");

  a_upper_limit_write: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_sfr_wr && i_sfr_addr == AWD_ADDR_UPPER_HIGH) |=> ##1
    (o_sfr_rdata == $past(i_sfr_wdata, 2) || $past(i_sfr_addr) != AWD_ADDR_UPPER_HIGH
     || $past(i_sfr_wr)))
    else $error("upper limit high byte did not read back");

  a_limit_words: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_sfr_wr && i_sfr_addr == AWD_ADDR_LOWER_LOW) |=>
    lower_word[7:0] == $past(i_sfr_wdata) && lower_word[15:8] == $past(lower_high_reg))
    else $error("lower limit low byte not stored in bits 7:0");

  a_low_byte_upper: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_sfr_wr && i_sfr_addr == AWD_ADDR_UPPER_LOW) |=> upper_word[7:0] == $past(i_sfr_wdata))
    else $error("upper limit low byte not stored in bits 7:0");

  a_lower_high_byte: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_sfr_wr && i_sfr_addr == AWD_ADDR_LOWER_HIGH) |=> lower_word[15:8] == $past(i_sfr_wdata))
    else $error("lower limit high byte not stored in bits 15:8");

  a_sw_start_busy: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    sw_start |=> ##1 busy_reg)
    else $error("software start did not raise busy");

  a_result_checked: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (i_result_valid && window_hit) |=> window_reg ##1 o_window_match_flag)
    else $error("result hit not reflected on the flag output");

endmodule : awd_top

`default_nettype wire

// [tb/tb_awd_top.sv]
// Purpose: Self-checking bench for the converter window detector block
// Assumes: Register reads answer one cycle after the address is presented
// Notes: Inputs move 2 ns after each rising edge so sampling never races

`timescale 1ns/1ps
`default_nettype none

module tb_awd_top;
  import awd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Design connections
  logic i_clk_sys;
  logic i_rst_b;
  logic [7:0] i_sfr_addr;
  logic i_sfr_wr;
  logic [7:0] i_sfr_wdata;
  logic [7:0] o_sfr_rdata;
  logic [15:0] i_result_data;
  logic i_result_valid;
  logic o_convert_start;
  logic o_adc_enable;
  logic o_track_delayed;
  logic i_ext_convert_start_pin;
  logic i_timer3_ovf;
  logic [AWD_AUX_SOURCES-1:0] i_aux_ovf;
  logic o_window_match_flag;
  logic o_conversion_done_flag;
  logic o_busy;
  int err_total = 0;
  int n_checks = 0;
  int n_starts = 0;

  awd_top #(.DATA_WIDTH(16)) dut (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_result_data(i_result_data),
    .i_result_valid(i_result_valid), .o_convert_start(o_convert_start),
    .o_adc_enable(o_adc_enable), .o_track_delayed(o_track_delayed),
    .i_ext_convert_start_pin(i_ext_convert_start_pin), .i_timer3_ovf(i_timer3_ovf),
    .i_aux_ovf(i_aux_ovf), .o_window_match_flag(o_window_match_flag),
    .o_conversion_done_flag(o_conversion_done_flag), .o_busy(o_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // Start pulses are one cycle wide; count on the falling edge, where they are settled
  always @(negedge i_clk_sys) begin
    if (o_convert_start === 1'b1) n_starts++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks and bus tasks
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic chk_cnt(input string name, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      err_total++;
      $display("FAIL %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  // Every task enters and leaves 2 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask : step

  // One idle edge after each write, so a following write never re-raises the strobe at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    step(1);
    i_sfr_wr = 1'b0;
    step(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_sfr_addr = a;
    step(1);
    chk8("read data", exp, o_sfr_rdata);
  endtask : rd

  task automatic res(input logic [15:0] v);
    i_result_data = v;
    i_result_valid = 1'b1;
    step(1);
    i_result_valid = 1'b0;
    step(2);
  endtask : res

  // Clears flags, loads both limits, then offers one result
  task automatic win(input logic [15:0] lo, input logic [15:0] up, input logic [15:0] v,
                     input logic exp);
    wr(AWD_ADDR_CONTROL, 8'h80);
    wr(AWD_ADDR_LOWER_HIGH, lo[15:8]);
    wr(AWD_ADDR_LOWER_LOW, lo[7:0]);
    wr(AWD_ADDR_UPPER_HIGH, up[15:8]);
    wr(AWD_ADDR_UPPER_LOW, up[7:0]);
    res(v);
    chk8("window flag", {7'h0, exp}, {7'h0, o_window_match_flag});
  endtask : win

  // Fires one trigger source: 0..2 aux, 3 pin, 4 timer 3
  task automatic fire(input int src);
    if (src < 3) i_aux_ovf[src] = 1'b1;
    if (src == 3) i_ext_convert_start_pin = 1'b1;
    if (src == 4) i_timer3_ovf = 1'b1;
    step(1);
    i_aux_ovf = '0;
    i_timer3_ovf = 1'b0;
    step(6);
    i_ext_convert_start_pin = 1'b0;
    step(4);
  endtask : fire

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, sized well beyond the roughly 770 cycles the tests need
  initial begin
    repeat (6000) @(posedge i_clk_sys);
    err_total++;
    $display("FAIL watchdog expected finish seen hang");
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    logic [15:0] vals [8];
    logic exps [8];
    i_rst_b = 1'b0;
    i_sfr_addr = 8'h00;
    i_sfr_wr = 1'b0;
    i_sfr_wdata = 8'h00;
    i_result_data = 16'h0000;
    i_result_valid = 1'b0;
    i_ext_convert_start_pin = 1'b0;
    i_timer3_ovf = 1'b0;
    i_aux_ovf = '0;
    step(20);
    i_rst_b = 1'b1;
    step(1);

    // Reset values, then an unmapped address
    rd(AWD_ADDR_UPPER_LOW, 8'hff);
    rd(AWD_ADDR_UPPER_HIGH, 8'hff);
    rd(AWD_ADDR_LOWER_LOW, 8'h00);
    rd(AWD_ADDR_LOWER_HIGH, 8'h00);
    rd(AWD_ADDR_CONTROL, 8'h00);
    rd(8'hc7, AWD_UNMAPPED_READ);
    $display("test reset values done");

    // Each limit byte holds its own pattern
    wr(AWD_ADDR_UPPER_LOW, 8'h5a);
    wr(AWD_ADDR_UPPER_HIGH, 8'ha5);
    wr(AWD_ADDR_LOWER_LOW, 8'h3c);
    wr(AWD_ADDR_LOWER_HIGH, 8'hc3);
    wr(8'hc7, 8'h77);
    rd(AWD_ADDR_UPPER_LOW, 8'h5a);
    rd(AWD_ADDR_UPPER_HIGH, 8'ha5);
    rd(AWD_ADDR_LOWER_LOW, 8'h3c);
    rd(AWD_ADDR_LOWER_HIGH, 8'hc3);
    rd(8'hc7, AWD_UNMAPPED_READ);
    $display("test limit registers done");

    // Inside window: lower 0x0080 above upper 0x0040, edges excluded
    vals = '{16'h0040, 16'h0041, 16'h007f, 16'h0080, 16'h0000, 16'h0060, 16'hffff, 16'h0100};
    exps = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    foreach (vals[i]) win(16'h0080, 16'h0040, vals[i], exps[i]);
    $display("test inside window done");

    // Outside window: lower 0x0040 below upper 0x0080, edges excluded
    vals = '{16'h003f, 16'h0040, 16'h0080, 16'h0081, 16'h0000, 16'h0060, 16'hffff, 16'h0100};
    exps = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    foreach (vals[i]) win(16'h0040, 16'h0080, vals[i], exps[i]);
    $display("test outside window done");

    // Sticky flag survives a miss and clears only by a zero write
    win(16'h0040, 16'h0080, 16'h0010, 1'b1);
    res(16'h0060);
    chk8("sticky flag", 8'h01, {7'h0, o_window_match_flag});
    rd(AWD_ADDR_CONTROL, 8'ha8);
    chk8("done out", 8'h01, {7'h0, o_conversion_done_flag});
    wr(AWD_ADDR_CONTROL, 8'hc0);
    step(2);
    chk8("cleared flag", 8'h00, {7'h0, o_window_match_flag});
    chk8("enable out", 8'h01, {7'h0, o_adc_enable});
    chk8("track out", 8'h01, {7'h0, o_track_delayed});
    chk8("done cleared", 8'h00, {7'h0, o_conversion_done_flag});
    rd(AWD_ADDR_CONTROL, 8'hc0);
    // A hit in the same cycle as a clearing write must still set the flag
    i_result_data = 16'h0010;
    i_result_valid = 1'b1;
    i_sfr_addr = AWD_ADDR_CONTROL;
    i_sfr_wdata = 8'hc0;
    i_sfr_wr = 1'b1;
    step(1);
    i_result_valid = 1'b0;
    i_sfr_wr = 1'b0;
    step(2);
    chk8("hit beats clear", 8'h01, {7'h0, o_window_match_flag});
    $display("test sticky flag done");

    // Every start code against every trigger source
    for (int m = 0; m < 8; m++) begin
      wr(AWD_ADDR_CONTROL, {5'b10000, m[2:0]});
      for (int s = 0; s < 5; s++) begin
        n_starts = 0;
        fire(s);
        chk_cnt("start count", (m == s + 1) ? 1 : 0, n_starts);
      end
    end
    // Two timer overflows give two conversions
    wr(AWD_ADDR_CONTROL, 8'h85);
    n_starts = 0;
    fire(4);
    fire(4);
    chk_cnt("timer starts", 2, n_starts);
    $display("test start sources done");

    // Software start sets busy until the result arrives
    wr(AWD_ADDR_CONTROL, 8'h80);
    n_starts = 0;
    wr(AWD_ADDR_CONTROL, 8'h90);
    step(3);
    chk_cnt("soft starts", 1, n_starts);
    chk8("busy set", 8'h01, {7'h0, o_busy});
    res(16'h0020);
    chk8("busy clear", 8'h00, {7'h0, o_busy});
    $display("test software start done");
    complete_run();
  end

endmodule : tb_awd_top

`default_nettype wire
